// *** logic/uci_channel_irq.sv ***
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module uci_channel_irq
  import uci_pkg::*;
#(
  parameter int CHAR_BITS = UCI_CHAR_BITS
)(
  input wire logic ref_clk, // 10 MHz
  input wire logic rst, // sync, active high
  input wire logic [3:0] addr, // register offset
  input wire logic [7:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [7:0] rdata, // read data, cycle after rd
  input wire uci_dp_t dp, // data path status
  input wire logic cts_n, // modem pins, async
  input wire logic dsr_n, // async pin
  input wire logic ri_n, // async pin
  input wire logic cd_n, // async pin
  output logic irq, // channel interrupt
  output logic rx_pop, // pulse: pop rx head
  output logic tx_push, // pulse: push tx_data
  output logic [7:0] tx_data, // char written
  output uci_cfg_t cfg // configuration
);

  localparam logic [7:0] TO_COUNT = 8'(UCI_TO_CHARS * CHAR_BITS + UCI_TO_XBITS);

  // ==========================================================
  // trigger level lookup, used for rx and tx
  function automatic logic [7:0] trig_lvl(
    input logic [1:0] tab,
    input logic [1:0] sel,
    input logic [31:0] row,
    input logic [7:0] prog
  );
    logic [7:0] lvl;
    lvl = row[{sel, 3'b000} +: 8];
    if (tab == 2'b11)
    begin
      lvl = prog;
    end
    return lvl;
  endfunction

  // ==========================================================
  // pin synchronisers, order cd ri dsr cts
  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  logic [3:0] pin_q;

  // two flops before any use; third copy for change detect
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      pin_s1 <= 4'hf;
      pin_s2 <= 4'hf;
      pin_q <= 4'hf;
    end
    else
    begin
      pin_s1 <= {cd_n, ri_n, dsr_n, cts_n};
      pin_s2 <= pin_s1;
      pin_q <= pin_s2;
    end
  end

  // ==========================================================
  // state
  logic [7:0] interrupt_enable_reg, next_ier;
  uci_cfg_t next_cfg;
  logic lsr_pend, next_lsr_pend;
  logic ovr, next_ovr;
  logic tx_pend, next_tx_pend;
  logic to_pend, next_to_pend;
  logic xof_pend, next_xof_pend;
  logic spc_pend, next_spc_pend;
  logic cts_pend, next_cts_pend;
  logic rts_pend, next_rts_pend;
  logic [3:0] delta, next_delta;
  logic [3:0] fcs, next_fcs;
  logic [7:0] to_cnt, next_to_cnt;
  logic [7:0] prev_txl;
  logic prev_tgt;
  logic pop_d;
  logic rts_q;
  logic dtr_q;
  logic [7:0] next_rdata;
  logic next_irq;

  // ==========================================================
  // derived status
  logic [7:0] rx_trig;
  logic [7:0] tx_trig;
  logic thr_empty;
  logic all_empty;
  logic tgt_empty;
  logic rx_avail;
  logic [7:0] lsr_val;
  logic [7:0] msr_val;
  logic [5:0] isr_code;
  logic [7:0] isr_val;
  logic unlock;
  logic rd_data;
  logic wr_data;
  logic rd_isr;

  // level thresholds and empties
  always_comb
  begin
    unlock = cfg.enhanced_function_reg[UCI_EF_UNLOCK];
    rx_trig = trig_lvl(cfg.feature_control_reg[7:6], cfg.rx_sel, 32'h0, cfg.rx_trig_prog);
    tx_trig = trig_lvl(cfg.feature_control_reg[7:6], cfg.tx_sel, 32'h0, cfg.tx_trig_prog);
    if (cfg.feature_control_reg[7:6] != 2'b11)
    begin
      rx_trig = trig_lvl(2'b00, cfg.rx_sel, UCI_RX_TAB[cfg.feature_control_reg[7:6]], 8'h00);
      tx_trig = trig_lvl(2'b00, cfg.tx_sel, UCI_TX_TAB[cfg.feature_control_reg[7:6]], 8'h00);
    end
    thr_empty = (dp.tx_level == 8'h00);
    all_empty = thr_empty && dp.tsr_empty;
    // half duplex with fifos on waits for shift reg
    tgt_empty = (cfg.fifo_en && cfg.feature_control_reg[UCI_FC_485]) ? all_empty : thr_empty;
    rx_avail = cfg.fifo_en ? (dp.rx_level >= rx_trig) : (dp.rx_level != 8'h00);
  end

  // status register images
  always_comb
  begin
    // error bits 4:2 from head char only, bit 7 from whole fifo
    lsr_val = {dp.rx_fifo_err, all_empty, thr_empty, dp.rx_head_err, ovr,
               dp.rx_level != 8'h00};
    msr_val = {~pin_q, delta};
  end

  // priority encoder over enabled sources
  always_comb
  begin
    if (interrupt_enable_reg[UCI_IE_LS] && lsr_pend)
      isr_code = UCI_C_LSR;
    else if (interrupt_enable_reg[UCI_IE_RX] && rx_avail)
      isr_code = UCI_C_RXD;
    else if (interrupt_enable_reg[UCI_IE_RX] && to_pend)
      isr_code = UCI_C_RTO;
    else if (interrupt_enable_reg[UCI_IE_TX] && tx_pend)
      isr_code = UCI_C_TXR;
    else if (interrupt_enable_reg[UCI_IE_MS] && delta != 4'h0)
      isr_code = UCI_C_MSR;
    else if (unlock && interrupt_enable_reg[UCI_IE_XOF] && (xof_pend || spc_pend))
      isr_code = UCI_C_XOF;
    else if (unlock && ((interrupt_enable_reg[UCI_IE_CTS] && cts_pend) || (interrupt_enable_reg[UCI_IE_RTS] && rts_pend)))
      isr_code = UCI_C_FLW;
    else
      isr_code = UCI_C_NONE;
    isr_val = {cfg.fifo_en, cfg.fifo_en, isr_code};
  end

  // ==========================================================
  // register writes, flags and read data
  always_comb
  begin
    next_cfg = cfg;
    next_ier = interrupt_enable_reg;
    next_lsr_pend = lsr_pend;
    next_ovr = ovr;
    next_tx_pend = tx_pend;
    next_to_pend = to_pend;
    next_xof_pend = xof_pend;
    next_spc_pend = spc_pend;
    next_cts_pend = cts_pend;
    next_rts_pend = rts_pend;
    next_delta = delta;
    next_fcs = fcs;
    next_to_cnt = to_cnt;
    next_rdata = rdata;
    rd_data = rd && (addr == UCI_A_DATA);
    wr_data = wr && (addr == UCI_A_DATA);
    rd_isr = rd && (addr == UCI_A_ISR);

    // host writes
    if (wr)
    begin
      case (addr)
        UCI_A_IER:
        begin
          next_ier = {unlock ? wdata[7:5] : 3'b000, 1'b0, wdata[3:0]};
        end
        UCI_A_ISR:
        begin
          // other fields only take with enable bit set
          next_cfg.fifo_en = wdata[0];
          if (wdata[0])
          begin
            next_cfg.rx_sel = wdata[7:6];
            if (unlock)
              next_cfg.tx_sel = wdata[5:4];
          end
        end
        UCI_A_MCR: next_cfg.modem_control_reg = wdata;
        UCI_A_FEATURE_CONTROL_REG: next_cfg.feature_control_reg = wdata;
        UCI_A_EFR: next_cfg.enhanced_function_reg = wdata;
        UCI_A_TX_FIFO_TRIGGER_LEVEL: next_cfg.tx_trig_prog = wdata;
        UCI_A_RX_FIFO_TRIGGER_LEVEL: next_cfg.rx_trig_prog = wdata;
        UCI_A_FLOW_CHAR_STATUS: next_cfg.pause_char_first = wdata;
        UCI_A_PAUSE_CHAR_SECOND: next_cfg.pause_char_second = wdata;
        UCI_A_RESUME_CHAR_FIRST: next_cfg.resume_char_first = wdata;
        UCI_A_RESUME_CHAR_SECOND: next_cfg.resume_char_second = wdata;
        default: next_cfg = next_cfg;
      endcase
    end

    // read data mux, unmapped offsets read zero
    if (rd)
    begin
      case (addr)
        UCI_A_DATA: next_rdata = dp.rx_data;
        UCI_A_IER: next_rdata = interrupt_enable_reg;
        UCI_A_ISR: next_rdata = isr_val;
        UCI_A_MCR: next_rdata = cfg.modem_control_reg;
        UCI_A_LSR: next_rdata = lsr_val;
        UCI_A_MSR: next_rdata = msr_val;
        UCI_A_FEATURE_CONTROL_REG: next_rdata = cfg.feature_control_reg;
        UCI_A_EFR: next_rdata = cfg.enhanced_function_reg;
        UCI_A_TX_FIFO_TRIGGER_LEVEL: next_rdata = dp.tx_level;
        UCI_A_RX_FIFO_TRIGGER_LEVEL: next_rdata = dp.rx_level;
        UCI_A_FLOW_CHAR_STATUS: next_rdata = {4'h0, fcs};
        default: next_rdata = 8'h00;
      endcase
    end

    // clears first, so that same-cycle sets below win
    // status reads clear
    if (rd && addr == UCI_A_LSR)
    begin
      next_lsr_pend = 1'b0;
      next_ovr = 1'b0;
    end
    if (rd && addr == UCI_A_MSR)
    begin
      next_delta = 4'h0;
      next_cts_pend = 1'b0;
      next_rts_pend = 1'b0;
    end
    if (wr_data || (rd_isr && isr_code == UCI_C_TXR))
      next_tx_pend = 1'b0;
    if ((rd_isr && isr_code == UCI_C_XOF) || dp.xon_det)
      next_xof_pend = 1'b0;
    if ((rd_isr && isr_code == UCI_C_XOF) || dp.rx_push)
      next_spc_pend = 1'b0;
    if (rd && addr == UCI_A_FLOW_CHAR_STATUS)
      next_fcs = 4'h0;
    if (rd_data)
      next_to_pend = 1'b0;

    // on arrival and again at head
    if ((dp.rx_push && dp.rx_push_err != 3'b000) || dp.rx_overrun ||
        (pop_d && dp.rx_head_err != 3'b000))
      next_lsr_pend = 1'b1;
    if (dp.rx_overrun)
      next_ovr = 1'b1;
    if ((cfg.fifo_en && prev_txl >= tx_trig && dp.tx_level < tx_trig) ||
        (tgt_empty && !prev_tgt))
      next_tx_pend = 1'b1;
    next_delta = next_delta | (pin_s2 ^ pin_q);
    if (dp.xoff_det)
      next_xof_pend = 1'b1;
    if (dp.spec_det)
      next_spc_pend = 1'b1;
    // cts or dsr rising, auto mode
    if (unlock && cfg.enhanced_function_reg[UCI_EF_ACTS] &&
        (cfg.modem_control_reg[UCI_MC_SEL] ? (pin_s2[1] && !pin_q[1]) : (pin_s2[0] && !pin_q[0])))
      next_cts_pend = 1'b1;
    // rts or dtr rising, auto mode
    if (unlock && cfg.enhanced_function_reg[UCI_EF_ARTS] &&
        (cfg.modem_control_reg[UCI_MC_SEL] ? (dp.dtr_n && !dtr_q) : (dp.rts_n && !rts_q)))
      next_rts_pend = 1'b1;
    next_fcs = next_fcs | {dp.tx_xon_sent, dp.tx_xoff_sent, dp.xon_det, dp.xoff_det};

    // idle timer in bit times, restarted by any rx fifo push or data read
    if (dp.rx_push || rd_data || dp.rx_level == 8'h00 || !cfg.fifo_en)
      next_to_cnt = 8'h00;
    else if (dp.bit_tick && to_cnt != TO_COUNT)
    begin
      next_to_cnt = to_cnt + 8'h01;
      if (to_cnt == TO_COUNT - 8'h01)
        next_to_pend = 1'b1;
    end

    next_irq = (isr_code != UCI_C_NONE);
  end

  // ==========================================================
  // registers
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      cfg <= '0;
      interrupt_enable_reg <= UCI_RST_REG;
      lsr_pend <= 1'b0;
      ovr <= 1'b0;
      tx_pend <= 1'b0;
      to_pend <= 1'b0;
      xof_pend <= 1'b0;
      spc_pend <= 1'b0;
      cts_pend <= 1'b0;
      rts_pend <= 1'b0;
      delta <= 4'h0;
      fcs <= 4'h0;
      to_cnt <= 8'h00;
      // starts empty, so no tx event fires out of reset
      prev_txl <= 8'h00;
      prev_tgt <= 1'b1;
      pop_d <= 1'b0;
      rts_q <= 1'b1;
      dtr_q <= 1'b1;
      rdata <= UCI_RST_REG;
      irq <= 1'b0;
      rx_pop <= 1'b0;
      tx_push <= 1'b0;
      tx_data <= UCI_RST_REG;
    end
    else
    begin
      cfg <= next_cfg;
      interrupt_enable_reg <= next_ier;
      lsr_pend <= next_lsr_pend;
      ovr <= next_ovr;
      tx_pend <= next_tx_pend;
      to_pend <= next_to_pend;
      xof_pend <= next_xof_pend;
      spc_pend <= next_spc_pend;
      cts_pend <= next_cts_pend;
      rts_pend <= next_rts_pend;
      delta <= next_delta;
      fcs <= next_fcs;
      to_cnt <= next_to_cnt;
      prev_txl <= dp.tx_level;
      prev_tgt <= tgt_empty;
      // head changes the cycle after a pop
      pop_d <= rx_pop;
      rts_q <= dp.rts_n;
      dtr_q <= dp.dtr_n;
      rdata <= next_rdata;
      irq <= next_irq;
      rx_pop <= rd_data;
      tx_push <= wr_data;
      tx_data <= wr_data ? wdata : tx_data;
    end
  end

endmodule // uci_channel_irq
`default_nettype wire

// *** logic/uci_pkg.sv ***
`default_nettype none
package uci_pkg;
  // ==========================================================
  // register offsets within one channel
  localparam logic [3:0] UCI_A_DATA = 4'h0; // rx holding rd, tx holding wr
  localparam logic [3:0] UCI_A_IER = 4'h1;
  localparam logic [3:0] UCI_A_ISR = 4'h2; // source rd, fifo control wr
  localparam logic [3:0] UCI_A_MCR = 4'h4;
  localparam logic [3:0] UCI_A_LSR = 4'h5;
  localparam logic [3:0] UCI_A_MSR = 4'h6;
  localparam logic [3:0] UCI_A_FEATURE_CONTROL_REG = 4'h8;
  localparam logic [3:0] UCI_A_EFR = 4'h9;
  localparam logic [3:0] UCI_A_TX_FIFO_TRIGGER_LEVEL = 4'ha; // tx count rd
  localparam logic [3:0] UCI_A_RX_FIFO_TRIGGER_LEVEL = 4'hb; // rx count rd
  localparam logic [3:0] UCI_A_FLOW_CHAR_STATUS = 4'hc; // flow status rd, pause 1 wr
  localparam logic [3:0] UCI_A_PAUSE_CHAR_SECOND = 4'hd;
  localparam logic [3:0] UCI_A_RESUME_CHAR_FIRST = 4'he;
  localparam logic [3:0] UCI_A_RESUME_CHAR_SECOND = 4'hf;
  // ==========================================================
  // interrupt source codes, bits 5:0
  localparam logic [5:0] UCI_C_LSR = 6'h06;
  localparam logic [5:0] UCI_C_RXD = 6'h04;
  localparam logic [5:0] UCI_C_RTO = 6'h0c;
  localparam logic [5:0] UCI_C_TXR = 6'h02;
  localparam logic [5:0] UCI_C_MSR = 6'h00;
  localparam logic [5:0] UCI_C_XOF = 6'h10;
  localparam logic [5:0] UCI_C_FLW = 6'h20;
  localparam logic [5:0] UCI_C_NONE = 6'h01;
  // ==========================================================
  // field positions
  localparam int UCI_IE_RX = 0;
  localparam int UCI_IE_TX = 1;
  localparam int UCI_IE_LS = 2;
  localparam int UCI_IE_MS = 3;
  localparam int UCI_IE_XOF = 5;
  localparam int UCI_IE_RTS = 6;
  localparam int UCI_IE_CTS = 7;
  localparam int UCI_EF_UNLOCK = 4;
  localparam int UCI_EF_ARTS = 6;
  localparam int UCI_EF_ACTS = 7;
  localparam int UCI_MC_SEL = 2;
  localparam int UCI_FC_485 = 5;
  localparam logic [7:0] UCI_RST_REG = 8'h00;
  // ==========================================================
  // receive timeout: char times plus extra bit times
  localparam int UCI_TO_CHARS = 4;
  localparam int UCI_TO_XBITS = 12;
  localparam int UCI_CHAR_BITS = 10;
  // ==========================================================
  // trigger tables a..c, four levels per table, level 0 lowest byte
  localparam logic [2:0][31:0] UCI_RX_TAB = {
    {8'h3c, 8'h38, 8'h10, 8'h08},
    {8'h1c, 8'h18, 8'h10, 8'h08},
    {8'h0e, 8'h08, 8'h04, 8'h01}};
  localparam logic [2:0][31:0] UCI_TX_TAB = {
    {8'h38, 8'h20, 8'h10, 8'h08},
    {8'h1e, 8'h18, 8'h08, 8'h10},
    {8'h01, 8'h01, 8'h01, 8'h01}};
  // ==========================================================
  // from the channel data path, same clock
  typedef struct packed {
    logic rx_push; // char entered rx fifo
    logic [2:0] rx_push_err; // its break, framing, parity
    logic rx_overrun; // overrun event
    logic [7:0] rx_level;
    logic [2:0] rx_head_err; // head char break, framing, parity
    logic rx_fifo_err; // any errored char in fifo
    logic [7:0] rx_data; // head char
    logic [7:0] tx_level;
    logic tsr_empty;
    logic bit_tick; // one pulse per bit time
    logic xoff_det;
    logic xon_det;
    logic spec_det;
    logic tx_xon_sent;
    logic tx_xoff_sent;
    logic rts_n; // flow logic pin levels
    logic dtr_n;
  } uci_dp_t;
  // configuration held by the channel
  typedef struct packed {
    logic fifo_en;
    logic [1:0] rx_sel;
    logic [1:0] tx_sel;
    logic [7:0] modem_control_reg;
    logic [7:0] feature_control_reg;
    logic [7:0] enhanced_function_reg;
    logic [7:0] rx_trig_prog;
    logic [7:0] tx_trig_prog;
    logic [7:0] pause_char_first;
    logic [7:0] pause_char_second;
    logic [7:0] resume_char_first;
    logic [7:0] resume_char_second;
  } uci_cfg_t;
endpackage
`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import uci_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, tx_data, d;
  logic wr, rd, irq, rx_pop, tx_push;
  logic cts_n = 1'b1;
  uci_dp_t dp;
  uci_cfg_t cfg;
  int err_count = 0;
  int n_compared = 0;
  always #50 ref_clk = ~ref_clk;
  uci_channel_irq i_uci_channel_irq (.ref_clk(ref_clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .dp(dp), .cts_n(cts_n),
    .dsr_n(1'b1), .ri_n(1'b1), .cd_n(1'b1), .irq(irq), .rx_pop(rx_pop),
    .tx_push(tx_push), .tx_data(tx_data), .cfg(cfg));
  uci_host_model i_host (.ref_clk(ref_clk), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata));
  // ==========================================================
  // checking helpers
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rchk(string what, logic [3:0] a, logic [7:0] exp);
    i_host.rd_reg(a, d);
    chk(what, exp, d);
  endtask
  // bounded wait, the output lags its cause by a few cycles
  task automatic wirq(logic v);
    int i;
    i = 0;
    while (irq !== v && i < 20)
    begin
      @(posedge ref_clk);
      #1 i++;
    end
    chk("irq", {7'h0, v}, {7'h0, irq});
  endtask
  task automatic final_report();
    $display("mismatches %0d comparisons %0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial
  begin
    dp = '0;
    dp.tsr_empty = 1'b1;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    rchk("source", 4'h2, 8'h01);
    rchk("enable", 4'h1, 8'h00);
    rchk("unmapped", 4'h3, 8'h00);
    i_host.wr_reg(4'h2, 8'h01);
    rchk("source", 4'h2, 8'hc1);
    // polled mode: fifos on, low enables clear
    @(posedge ref_clk);
    dp.rx_level <= 8'h03;
    dp.rx_fifo_err <= 1'b1;
    rchk("line status", 4'h5, 8'he1);
    rchk("rx count", 4'hb, 8'h03);
    chk("irq", 8'h00, {7'h0, irq});
    i_host.wr_reg(4'hb, 8'h2a);
    chk("rx trig", 8'h2a, cfg.rx_trig_prog);
    i_host.wr_reg(4'ha, 8'h05);
    chk("tx trig", 8'h05, cfg.tx_trig_prog);
    // errored char arrives behind a clean head
    i_host.wr_reg(4'h1, 8'h04);
    @(posedge ref_clk);
    dp.rx_push <= 1'b1;
    dp.rx_push_err <= 3'b001;
    dp.rx_level <= 8'h02;
    @(posedge ref_clk);
    dp.rx_push <= 1'b0;
    wirq(1'b1);
    rchk("source", 4'h2, 8'hc6);
    rchk("line status", 4'h5, 8'he1);
    wirq(1'b0);
    // the errored char reaches the head
    @(posedge ref_clk);
    dp.rx_head_err <= 3'b001;
    dp.rx_level <= 8'h01;
    i_host.rd_reg(4'h0, d);
    wirq(1'b1);
    rchk("line status", 4'h5, 8'he5);
    wirq(1'b0);
    // two sources at once, highest served first
    i_host.wr_reg(4'h1, 8'h0c);
    @(posedge ref_clk);
    cts_n <= 1'b0;
    dp.rx_push <= 1'b1;
    dp.rx_push_err <= 3'b010;
    @(posedge ref_clk);
    dp.rx_push <= 1'b0;
    repeat (10) @(posedge ref_clk);
    rchk("source", 4'h2, 8'hc6);
    i_host.rd_reg(4'h5, d);
    rchk("source", 4'h2, 8'hc0);
    rchk("modem status", 4'h6, 8'h11);
    rchk("source", 4'h2, 8'hc1);
    wirq(1'b0);
    // automatic flow control, input rising edge
    i_host.wr_reg(4'h9, 8'h90);
    i_host.wr_reg(4'h1, 8'h80);
    @(posedge ref_clk);
    cts_n <= 1'b1;
    wirq(1'b1);
    rchk("source", 4'h2, 8'he0);
    rchk("modem status", 4'h6, 8'h01);
    wirq(1'b0);
    // pause char, then resume clears it
    i_host.wr_reg(4'h1, 8'h20);
    @(posedge ref_clk);
    dp.xoff_det <= 1'b1;
    dp.tx_xon_sent <= 1'b1;
    @(posedge ref_clk);
    dp.xoff_det <= 1'b0;
    dp.tx_xon_sent <= 1'b0;
    wirq(1'b1);
    rchk("source", 4'h2, 8'hd0);
    rchk("source", 4'h2, 8'hc1);
    rchk("flow status", 4'hc, 8'h09);
    rchk("flow status", 4'hc, 8'h00);
    @(posedge ref_clk);
    dp.xoff_det <= 1'b1;
    @(posedge ref_clk);
    dp.xoff_det <= 1'b0;
    wirq(1'b1);
    @(posedge ref_clk);
    dp.xon_det <= 1'b1;
    @(posedge ref_clk);
    dp.xon_det <= 1'b0;
    wirq(1'b0);
    // timeout below trigger 14: one tick short, then exact
    i_host.wr_reg(4'h1, 8'h01);
    i_host.wr_reg(4'h2, 8'hc1);
    @(posedge ref_clk);
    dp.rx_head_err <= 3'b000;
    dp.rx_level <= 8'h02;
    dp.bit_tick <= 1'b1;
    repeat (4 * UCI_CHAR_BITS + 11) @(posedge ref_clk);
    dp.bit_tick <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk("irq", 8'h00, {7'h0, irq});
    dp.bit_tick <= 1'b1;
    @(posedge ref_clk);
    dp.bit_tick <= 1'b0;
    wirq(1'b1);
    rchk("source", 4'h2, 8'hcc);
    i_host.rd_reg(4'h0, d);
    wirq(1'b0);
    // rx data follows trigger level 4
    i_host.wr_reg(4'h2, 8'h41);
    @(posedge ref_clk);
    dp.rx_level <= 8'h03;
    repeat (4) @(posedge ref_clk);
    chk("irq", 8'h00, {7'h0, irq});
    dp.rx_level <= 8'h04;
    wirq(1'b1);
    rchk("source", 4'h2, 8'hc4);
    @(posedge ref_clk);
    dp.rx_level <= 8'h03;
    wirq(1'b0);
    i_host.wr_reg(4'h0, 8'h5a);
    chk("tx char", 8'h5a, tx_data);
    // tx fifo drains below trigger one, ready raised then cleared by source read
    i_host.wr_reg(4'h1, 8'h02);
    @(posedge ref_clk);
    dp.tx_level <= 8'h01;
    repeat (2) @(posedge ref_clk);
    dp.tx_level <= 8'h00;
    wirq(1'b1);
    rchk("source", 4'h2, 8'hc2);
    rchk("source", 4'h2, 8'hc1);
    final_report();
  end
  // watchdog well past the few hundred cycles the tests take
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    final_report();
  end
endmodule // tb_top
`default_nettype wire

// *** testbench/uci_channel_irq_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module uci_channel_irq_monitor
  import uci_pkg::*;
(
  input wire logic ref_clk, // clock
  input wire logic rst, // reset
  input wire logic [3:0] addr, // offset
  input wire logic [7:0] wdata, // wr data
  input wire logic wr, // write
  input wire logic rd, // read
  input wire logic [7:0] rdata, // rd data
  input wire uci_dp_t dp, // data path
  input wire logic rx_pop, // pop pulse
  input wire logic tx_push, // push pulse
  input wire logic [7:0] tx_data, // tx char
  input wire uci_cfg_t cfg // config
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // ==========================================================
  // bus steps
  sequence s_rd(logic [3:0] a);
    rd && addr == a;
  endsequence
  sequence s_wr(logic [3:0] a);
    wr && addr == a;
  endsequence
  // ==========================================================
  // read answers, taken from the strobe edge
  a_hole_zero: assert property (rd && (addr == 4'h3 || addr == 4'h7) |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_count_read: assert property (s_rd(4'hb) |=> rdata == $past(dp.rx_level))
    else $error("rx count read mismatch");
  a_line_bits: assert property (s_rd(4'h5) |=>
    rdata[0] == ($past(dp.rx_level) != 8'h00) && rdata[4:2] == $past(dp.rx_head_err)
    && rdata[7] == $past(dp.rx_fifo_err) && rdata[5] == ($past(dp.tx_level) == 8'h00)
    && rdata[6] == ($past(dp.tx_level) == 8'h00 && $past(dp.tsr_empty)))
    else $error("line status bits mismatch");
  a_src_top: assert property (s_rd(4'h2) |=> rdata[7:6] == {2{$past(cfg.fifo_en)}})
    else $error("source top bits mismatch");
  a_src_code: assert property (s_rd(4'h2) |=>
    rdata[5:0] inside {6'h01, 6'h06, 6'h04, 6'h0c, 6'h02, 6'h00, 6'h10, 6'h20})
    else $error("source code illegal");
  a_flow_upper: assert property (s_rd(4'hc) |=> rdata[7:4] == 4'h0)
    else $error("flow status upper bits set");
  // ==========================================================
  // side effects of data and trigger level accesses
  a_pop_pulse: assert property (s_rd(4'h0) |=> rx_pop)
    else $error("rx read gave no pop");
  a_pop_cause: assert property (rx_pop |-> $past(rd) && $past(addr) == 4'h0)
    else $error("pop without rx read");
  a_push_data: assert property (s_wr(4'h0) |=> tx_push && tx_data == $past(wdata))
    else $error("tx write not pushed");
  a_rx_trig: assert property (s_wr(4'hb) |=> cfg.rx_trig_prog == $past(wdata))
    else $error("rx trigger not loaded");
  a_tx_trig: assert property (s_wr(4'ha) |=> cfg.tx_trig_prog == $past(wdata))
    else $error("tx trigger not loaded");
endmodule // uci_channel_irq_monitor
bind uci_channel_irq uci_channel_irq_monitor i_uci_channel_irq_monitor (
  .ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .dp(dp), .rx_pop(rx_pop), .tx_push(tx_push), .tx_data(tx_data),
  .cfg(cfg));
`default_nettype wire

// *** testbench/uci_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module uci_host_model (
  input wire logic ref_clk, // clock
  output logic [3:0] addr, // offset
  output logic [7:0] wdata, // wr data
  output logic wr, // write
  output logic rd, // read
  input wire logic [7:0] rdata // rd data
);
  // idle bus from time zero
  initial
  begin
    addr = 4'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  // one-cycle write strobe
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
    // let the launched registers settle before the caller looks at them
    #1;
  endtask
  // data valid from the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
endmodule // uci_host_model
`default_nettype wire
